// ==== core/bcc_pkg.sv ====
// Package for the buck converter control register bank.
// Holds the register map, field layouts, reset values, select codes and timing constants.
// Assumes every user writes package::name and imports nothing.
package bcc_pkg;

  // Register offsets as printed; these are word indexes, byte address is four times the index.
  localparam logic [31:0] OFF_AUX18_RAIL = 32'h50000096;
  localparam logic [31:0] OFF_RET_A = 32'h50000098;
  localparam logic [31:0] OFF_RET_B = 32'h5000009A;
  localparam logic [31:0] OFF_TRIM = 32'h5000009C;
  localparam logic [31:0] OFF_TEST_A = 32'h5000009E;
  localparam logic [31:0] OFF_TEST_B = 32'h500000A0;

  // Register layouts, most significant field first.
  typedef struct packed {
    logic aux18OutEnHighbat;
    logic aux18OutEnLowbat;
    logic [3:0] aux18MaxIlimitLowbat;
    logic [4:0] aux18IdleHysteresis;
    logic [4:0] aux18IdleMinimum;
  } bcc_aux18_rail_t;

  typedef struct packed {
    logic [2:0] chargeCyclesHi;
    logic [4:0] sleepIlimitHi;
    logic [2:0] chargeCyclesLo;
    logic [4:0] sleepIlimitLo;
  } bcc_ret_t;

  typedef struct packed {
    logic [1:0] reserved;
    logic highCmpTrimManual;
    logic [5:0] highCmpTrimValue;
    logic lowCmpTrimManual;
    logic [5:0] lowCmpTrimValue;
  } bcc_trim_t;

  typedef struct packed {
    logic cmpClockOverride;
    logic ilimitOverride;
    logic [2:0] railMonitorSelect;
    logic [2:0] analogTestbusSelect;
    logic idleOverride;
    logic aux18SwitchOverride;
    logic coreSwitchOverride;
    logic io18SwitchOverride;
    logic rail14SwitchOverride;
    logic freewheelSwitchOverride;
    logic lowsideSwitchOverride;
    logic highsideSwitchOverride;
  } bcc_test_a_t;

  typedef struct packed {
    logic [2:0] reserved;
    logic [3:0] cmpClockForcedValues;
    logic [4:0] testIlimitValue;
    logic [3:0] testbusRegisterSelect;
  } bcc_test_b_t;

  // Reset values.
  localparam bcc_aux18_rail_t AUX18_RAIL_RST = '{aux18OutEnHighbat: 1'h1, aux18OutEnLowbat: 1'h0,
    aux18MaxIlimitLowbat: 4'hF, aux18IdleHysteresis: 5'h04, aux18IdleMinimum: 5'h10};
  localparam bcc_ret_t RET_A_RST = '{chargeCyclesHi: 3'h5, sleepIlimitHi: 5'h0A,
    chargeCyclesLo: 3'h5, sleepIlimitLo: 5'h06};
  localparam bcc_ret_t RET_B_RST = '{chargeCyclesHi: 3'h5, sleepIlimitHi: 5'h0A,
    chargeCyclesLo: 3'h2, sleepIlimitLo: 5'h06};
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [4:0] ADAPT_RST = 5'h04;

  // Rail monitor and analogue test bus select codes.
  localparam logic [2:0] MON_RAIL14 = 3'h1;
  localparam logic [2:0] MON_IO18 = 3'h2;
  localparam logic [2:0] MON_CORE = 3'h3;
  localparam logic [2:0] MON_PA = 3'h4;
  localparam logic [2:0] ATB_HIGH_GND = 3'h1;
  localparam logic [2:0] ATB_LOW_SUPPLY = 3'h2;
  localparam logic [2:0] ATB_BUF12 = 3'h3;

  // Test register select: 1..5 status 0..4, 6..9 trim 0..3, else none.
  localparam logic [3:0] TREG_FIRST = 4'h1;
  localparam logic [3:0] TREG_LAST = 4'h9;
  localparam int TREG_COUNT = 9;

  // Idle timing.
  localparam int IDLE_STEP_NS = 125;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [15:0] IDLE_STEP = 16'(IDLE_STEP_NS);
  localparam logic [15:0] IDLE_TICK = 16'(CLK_PERIOD_NS);

endpackage

// ==== core/bcc_sync.sv ====
// Three-stage synchroniser for a level arriving from the analogue side.
// Assumes the input is asynchronous to mclk; the output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module bcc_sync (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Level in and filtered level out.
  input wire logic asyncIn,
  output logic syncOut
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Stage one feeds only stage two, so metastability cannot reach any decision logic.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // The output follows only when the two settled stages agree.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      syncOut <= 1'b0;
    end else if (stage2 == stage3) begin
      syncOut <= stage3;
    end
  end

endmodule
`default_nettype wire

// ==== core/bcc_idle_adapt.sv ====
// Idle-time driven adaptation of the auxiliary rail current limit.
// Assumes idleLevel is already synchronised to mclk and is high while the converter idles.
`timescale 1ns/1ps
`default_nettype none
module bcc_idle_adapt (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Idle indication and settings.
  input wire logic idleLevel,
  input wire logic [4:0] idleMinimum,
  input wire logic [4:0] idleHysteresis,
  input wire logic [3:0] maxIlimit,
  // Adapted limit.
  output logic [4:0] adaptiveIlimit
);

  logic [15:0] idleNs;
  logic idleSeen;
  logic idleEnd;
  logic [15:0] minNs;
  logic [15:0] maxNs;
  logic tooShort;
  logic tooLong;

  // Idle time is kept in nanoseconds because the 125 ns step does not divide the clock period.
  localparam logic [15:0] IDLE_STEP_W = bcc_pkg::IDLE_STEP;
  assign minNs = 16'(idleMinimum * IDLE_STEP_W);
  assign maxNs = 16'((idleMinimum + idleHysteresis) * IDLE_STEP_W);
  assign idleEnd = idleSeen && !idleLevel;
  assign tooShort = idleNs < minNs;
  assign tooLong = idleNs > maxNs;

  // Measure the length of each idle period, saturating rather than wrapping.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idleNs <= 16'h0000;
      idleSeen <= 1'b0;
    end else begin
      idleSeen <= idleLevel;
      if (idleLevel) begin
        if (idleNs <= 16'hFFFF - bcc_pkg::IDLE_TICK) begin
          idleNs <= idleNs + bcc_pkg::IDLE_TICK;
        end
      end else begin
        idleNs <= 16'h0000;
      end
    end
  end

  // Step the limit once per completed idle period, bounded by zero and the low battery maximum.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adaptiveIlimit <= bcc_pkg::ADAPT_RST;
    end else if (idleEnd) begin
      if (tooShort && adaptiveIlimit < {1'b0, maxIlimit}) begin
        adaptiveIlimit <= adaptiveIlimit + 5'h01;
      end else if (tooLong && adaptiveIlimit != 5'h00) begin
        adaptiveIlimit <= adaptiveIlimit - 5'h01;
      end
    end
  end

  property p_raise;
    @(posedge mclk) disable iff (!rst_n)
      idleEnd && tooShort && adaptiveIlimit < {1'b0, maxIlimit} |=> adaptiveIlimit == $past(adaptiveIlimit) + 5'h01;
  endproperty
  a_raise: assert property (p_raise) else $error("Limit not raised after short idle.");

  property p_lower;
    @(posedge mclk) disable iff (!rst_n)
      idleEnd && tooLong && adaptiveIlimit != 5'h00 |=> adaptiveIlimit == $past(adaptiveIlimit) - 5'h01;
  endproperty
  a_lower: assert property (p_lower) else $error("Limit not lowered after long idle.");

endmodule
`default_nettype wire

// ==== core/bcc_regs.sv ====
// Buck converter control register bank with its test overrides and idle-time limit adaptation.
// Assumes an Avalon-MM master on mclk using word addresses equal to the printed register offsets.
// What this block does
// - Aux18 high-battery enable, bit 15, resets on.
// - Aux18 low-battery enable, bit 14, resets off.
// - Aux18 low-battery max limit, four bits, 0xF.
// - Idle longer than minimum plus hysteresis lowers limit.
// - Idle shorter than minimum raises limit; reset 0x10.
// - Sleep charge cycles 1+2N; aux18 resets 5.
// - Rail14 charge cycles bits 7:5 reset 2.
// - Sleep current limits 30 mA steps; aux18/io18 0xA.
// - Core and rail14 sleep limits reset 6.
// - High-side trim mode: 0 automatic, 1 manual.
// - High-side manual trim, signed magnitude six bits.
// - Low-side trim mode: 0 automatic, 1 manual.
// - Low-side manual trim, signed magnitude six bits.
// - Clock override stops automatic comparator clocking.
// - Forced clock bits drive pa, core, io18, rail14.
// - Current override substitutes test limit value.
// - Monitor select routes one rail to ADC.
// - Analogue test bus select picks one source.
// - Test bits force idle and individual switches.
// - Test register select puts readback on testbus.
`timescale 1ns/1ps
`default_nettype none
module bcc_regs #(
  parameter int READBACK_W = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Signals from the analogue converter.
  input wire logic converterIdle,
  input wire logic [3:0] autoCmpClk,
  input wire logic [5:0] autoHighTrim,
  input wire logic [5:0] autoLowTrim,
  input wire logic [bcc_pkg::TREG_COUNT*READBACK_W-1:0] readbackWords,
  // Register contents towards the converter.
  output bcc_pkg::bcc_aux18_rail_t aux18Ctrl,
  output bcc_pkg::bcc_ret_t sleepCtrlA,
  output bcc_pkg::bcc_ret_t sleepCtrlB,
  output bcc_pkg::bcc_test_a_t testForceA,
  // Resolved controls towards the converter.
  output logic [3:0] cmpClk,
  output logic [5:0] highCmpTrim,
  output logic [5:0] lowCmpTrim,
  output logic [4:0] ilimitSetting,
  output logic [4:0] adaptiveIlimit,
  output logic [3:0] monitorConnect,
  output logic [2:0] testbusConnect,
  output logic [READBACK_W-1:0] testbusWord
);

  bcc_pkg::bcc_trim_t trimCtrl;
  bcc_pkg::bcc_test_b_t testForceB;
  logic ack;
  logic idleSync;
  logic [15:0] readValue;
  logic [15:0] writeValue;
  logic [15:0] oldValue;
  logic writeNow;

  // Byte lane merge for the two implemented lanes.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // One wait cycle per access keeps the read path registered and easy to time.
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign writeNow = avs_write && ack;
  assign writeValue = merge(oldValue, avs_writedata, avs_byteenable);

  // Acknowledge one cycle after any request is seen.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    readValue = bcc_pkg::ZERO16;
    unique case (avs_address)
      bcc_pkg::OFF_AUX18_RAIL: readValue = aux18Ctrl;
      bcc_pkg::OFF_RET_A: readValue = sleepCtrlA;
      bcc_pkg::OFF_RET_B: readValue = sleepCtrlB;
      bcc_pkg::OFF_TRIM: readValue = trimCtrl;
      bcc_pkg::OFF_TEST_A: readValue = testForceA;
      bcc_pkg::OFF_TEST_B: readValue = testForceB;
      default: readValue = bcc_pkg::ZERO16;
    endcase
  end
  assign oldValue = readValue;

  // Read data is captured in the wait cycle and stands while the request is acknowledged.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack) begin
      avs_readdata <= {16'h0000, readValue};
    end
  end

  // Aux18 rail limit and idle control.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aux18Ctrl <= bcc_pkg::AUX18_RAIL_RST;
    end else if (writeNow && avs_address == bcc_pkg::OFF_AUX18_RAIL) begin
      aux18Ctrl <= bcc_pkg::bcc_aux18_rail_t'(writeValue);
    end
  end

  // Sleep retention: charge cycles and current limits per rail.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sleepCtrlA <= bcc_pkg::RET_A_RST;
      sleepCtrlB <= bcc_pkg::RET_B_RST;
    end else if (writeNow) begin
      if (avs_address == bcc_pkg::OFF_RET_A) begin
        sleepCtrlA <= bcc_pkg::bcc_ret_t'(writeValue);
      end
      if (avs_address == bcc_pkg::OFF_RET_B) begin
        sleepCtrlB <= bcc_pkg::bcc_ret_t'(writeValue);
      end
    end
  end

  // Comparator trim control; the two top bits are unused and held at zero.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trimCtrl <= bcc_pkg::bcc_trim_t'(bcc_pkg::ZERO16);
    end else if (writeNow && avs_address == bcc_pkg::OFF_TRIM) begin
      trimCtrl <= bcc_pkg::bcc_trim_t'(writeValue);
      trimCtrl.reserved <= 2'h0;
    end
  end

  // Test override registers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      testForceA <= bcc_pkg::bcc_test_a_t'(bcc_pkg::ZERO16);
      testForceB <= bcc_pkg::bcc_test_b_t'(bcc_pkg::ZERO16);
    end else if (writeNow) begin
      if (avs_address == bcc_pkg::OFF_TEST_A) begin
        testForceA <= bcc_pkg::bcc_test_a_t'(writeValue);
      end
      if (avs_address == bcc_pkg::OFF_TEST_B) begin
        testForceB <= bcc_pkg::bcc_test_b_t'(writeValue);
        testForceB.reserved <= 3'h0;
      end
    end
  end

  // The idle indication comes from the analogue side and is synchronised first.
  bcc_sync u_idle_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(converterIdle),
    .syncOut(idleSync)
  );

  bcc_idle_adapt u_adapt (
    .mclk(mclk),
    .rst_n(rst_n),
    .idleLevel(idleSync),
    .idleMinimum(aux18Ctrl.aux18IdleMinimum),
    .idleHysteresis(aux18Ctrl.aux18IdleHysteresis),
    .maxIlimit(aux18Ctrl.aux18MaxIlimitLowbat),
    .adaptiveIlimit(adaptiveIlimit)
  );

  // Comparator clocks and trims; manual modes replace the automatic values.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmpClk <= 4'h0;
      highCmpTrim <= 6'h00;
      lowCmpTrim <= 6'h00;
    end else begin
      cmpClk <= testForceB.cmpClockForcedValues;
      if (!testForceA.cmpClockOverride) begin
        cmpClk <= autoCmpClk;
      end
      highCmpTrim <= trimCtrl.highCmpTrimManual ? trimCtrl.highCmpTrimValue : autoHighTrim;
      lowCmpTrim <= trimCtrl.lowCmpTrimManual ? trimCtrl.lowCmpTrimValue : autoLowTrim;
    end
  end

  // Current limit setting: the test value overrides adaptation.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ilimitSetting <= bcc_pkg::ADAPT_RST;
    end else begin
      ilimitSetting <= testForceA.ilimitOverride ? testForceB.testIlimitValue : adaptiveIlimit;
    end
  end

  // Monitor and analogue test bus switches; unlisted codes close nothing.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      monitorConnect <= 4'h0;
      testbusConnect <= 3'h0;
    end else begin
      monitorConnect <= {testForceA.railMonitorSelect == bcc_pkg::MON_PA,
                         testForceA.railMonitorSelect == bcc_pkg::MON_CORE,
                         testForceA.railMonitorSelect == bcc_pkg::MON_IO18,
                         testForceA.railMonitorSelect == bcc_pkg::MON_RAIL14};
      testbusConnect <= {testForceA.analogTestbusSelect == bcc_pkg::ATB_BUF12,
                         testForceA.analogTestbusSelect == bcc_pkg::ATB_LOW_SUPPLY,
                         testForceA.analogTestbusSelect == bcc_pkg::ATB_HIGH_GND};
    end
  end

  // Readback word onto the digital test bus; out-of-range codes give zero.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      testbusWord <= '0;
    end else if (testForceB.testbusRegisterSelect >= bcc_pkg::TREG_FIRST &&
                 testForceB.testbusRegisterSelect <= bcc_pkg::TREG_LAST) begin
      testbusWord <= readbackWords[(testForceB.testbusRegisterSelect - bcc_pkg::TREG_FIRST) * READBACK_W +: READBACK_W];
    end else begin
      testbusWord <= '0;
    end
  end

  property p_wait_once;
    @(posedge mclk) disable iff (!rst_n)
      avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("Wait request held more than one cycle.");

  property p_upper_zero;
    @(posedge mclk) disable iff (!rst_n)
      avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Unused read bits not zero.");

  property p_write_aux18_rail;
    @(posedge mclk) disable iff (!rst_n)
      avs_write && !avs_waitrequest && avs_address == bcc_pkg::OFF_AUX18_RAIL && avs_byteenable == 4'hF
      |=> aux18Ctrl == $past(avs_writedata[15:0]);
  endproperty
  a_write_aux18_rail: assert property (p_write_aux18_rail) else $error("Aux18 register write lost.");

  property p_reset_vals;
    @(posedge mclk)
      !rst_n |=> aux18Ctrl == bcc_pkg::AUX18_RAIL_RST && sleepCtrlA == bcc_pkg::RET_A_RST && sleepCtrlB == bcc_pkg::RET_B_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Reset values wrong.");

  property p_clk_forced;
    @(posedge mclk) disable iff (!rst_n)
      testForceA.cmpClockOverride ##1 testForceA.cmpClockOverride |-> cmpClk == $past(testForceB.cmpClockForcedValues);
  endproperty
  a_clk_forced: assert property (p_clk_forced) else $error("Forced comparator clock not applied.");

  property p_clk_auto;
    @(posedge mclk) disable iff (!rst_n)
      !testForceA.cmpClockOverride |=> cmpClk == $past(autoCmpClk);
  endproperty
  a_clk_auto: assert property (p_clk_auto) else $error("Automatic comparator clock not followed.");

  property p_ilimit;
    @(posedge mclk) disable iff (!rst_n)
      testForceA.ilimitOverride |=> ilimitSetting == $past(testForceB.testIlimitValue);
  endproperty
  a_ilimit: assert property (p_ilimit) else $error("Forced current limit not applied.");

  property p_trim_high;
    @(posedge mclk) disable iff (!rst_n)
      trimCtrl.highCmpTrimManual |=> highCmpTrim == $past(trimCtrl.highCmpTrimValue);
  endproperty
  a_trim_high: assert property (p_trim_high) else $error("Manual high-side trim not applied.");

  property p_trim_low;
    @(posedge mclk) disable iff (!rst_n)
      !trimCtrl.lowCmpTrimManual |=> lowCmpTrim == $past(autoLowTrim);
  endproperty
  a_trim_low: assert property (p_trim_low) else $error("Automatic low-side trim not followed.");

  property p_trim_low_manual;
    @(posedge mclk) disable iff (!rst_n)
      trimCtrl.lowCmpTrimManual |=> lowCmpTrim == $past(trimCtrl.lowCmpTrimValue);
  endproperty
  a_trim_low_manual: assert property (p_trim_low_manual) else $error("Manual low trim not applied.");

  property p_trim_high_auto;
    @(posedge mclk) disable iff (!rst_n)
      !trimCtrl.highCmpTrimManual |=> highCmpTrim == $past(autoHighTrim);
  endproperty
  a_trim_high_auto: assert property (p_trim_high_auto) else $error("Automatic high trim not followed.");

  property p_ilimit_adapt;
    @(posedge mclk) disable iff (!rst_n)
      !testForceA.ilimitOverride |=> ilimitSetting == $past(adaptiveIlimit);
  endproperty
  a_ilimit_adapt: assert property (p_ilimit_adapt) else $error("Adapted current limit not used.");

  property p_write_ret_a;
    @(posedge mclk) disable iff (!rst_n)
      avs_write && !avs_waitrequest && avs_address == bcc_pkg::OFF_RET_A && avs_byteenable == 4'hF
      |=> sleepCtrlA == $past(avs_writedata[15:0]);
  endproperty
  a_write_ret_a: assert property (p_write_ret_a) else $error("Sleep retention write lost.");

  property p_monitor_pa;
    @(posedge mclk) disable iff (!rst_n)
      testForceA.railMonitorSelect == bcc_pkg::MON_PA |=> monitorConnect == 4'h8;
  endproperty
  a_monitor_pa: assert property (p_monitor_pa) else $error("Pa rail monitor not connected.");

  property p_monitor_none;
    @(posedge mclk) disable iff (!rst_n)
      testForceA.railMonitorSelect > bcc_pkg::MON_PA |=> monitorConnect == 4'h0;
  endproperty
  a_monitor_none: assert property (p_monitor_none) else $error("Monitor connected on unused code.");

  property p_testbus_buf;
    @(posedge mclk) disable iff (!rst_n)
      testForceA.analogTestbusSelect == bcc_pkg::ATB_BUF12 |=> testbusConnect == 3'h4;
  endproperty
  a_testbus_buf: assert property (p_testbus_buf) else $error("Buffer output not on test bus.");

  property p_treg_none;
    @(posedge mclk) disable iff (!rst_n)
      testForceB.testbusRegisterSelect > bcc_pkg::TREG_LAST |=> testbusWord == '0;
  endproperty
  a_treg_none: assert property (p_treg_none) else $error("Test bus word not zero for unused code.");

endmodule
`default_nettype wire

// ==== tb/bcc_regs_test.sv ====
// Self-checking testbench for the buck converter control register bank.
// Assumes bcc_pkg and bcc_regs are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module bcc_regs_test;
  // Clock, reset and register bus.
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] avs_address = 32'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // Converter side.
  logic converterIdle = 1'b0;
  logic [3:0] autoCmpClk = 4'h0;
  logic [5:0] autoHighTrim = 6'h0;
  logic [5:0] autoLowTrim = 6'h0;
  logic [143:0] readbackWords = 144'h0;
  bcc_pkg::bcc_aux18_rail_t aux18Ctrl;
  bcc_pkg::bcc_ret_t sleepCtrlA;
  bcc_pkg::bcc_ret_t sleepCtrlB;
  bcc_pkg::bcc_test_a_t testForceA;
  logic [3:0] cmpClk, monitorConnect;
  logic [5:0] highCmpTrim, lowCmpTrim;
  logic [4:0] ilimitSetting, adaptiveIlimit;
  logic [2:0] testbusConnect;
  logic [15:0] testbusWord;
  // Reference model: register images, writable masks and the adapted limit.
  logic [15:0] mdl [6];
  logic [15:0] mask [6];
  logic [31:0] offs [6];
  logic [31:0] rnd = 32'h0A757BC3;
  int adapt = 4;
  int errTotal = 0;
  int checksDone = 0;

  bcc_regs bcc_regs_i (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .converterIdle(converterIdle), .autoCmpClk(autoCmpClk),
    .autoHighTrim(autoHighTrim), .autoLowTrim(autoLowTrim), .readbackWords(readbackWords),
    .aux18Ctrl(aux18Ctrl), .sleepCtrlA(sleepCtrlA), .sleepCtrlB(sleepCtrlB), .testForceA(testForceA),
    .cmpClk(cmpClk), .highCmpTrim(highCmpTrim), .lowCmpTrim(lowCmpTrim), .ilimitSetting(ilimitSetting),
    .adaptiveIlimit(adaptiveIlimit), .monitorConnect(monitorConnect), .testbusConnect(testbusConnect),
    .testbusWord(testbusWord));

  // A 100 ns clock period.
  always #50 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    if (errTotal == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [15:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      errTotal++;
      conclude();
    end
  endtask

  task automatic wreg(input int k, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, offs[k], d, q);
    mdl[k] = d & mask[k];
  endtask

  task automatic rchk(input int k);
    logic [31:0] q;
    bus(1'b0, offs[k], 16'h0000, q);
    chk(q, {16'h0000, mdl[k]});
  endtask

  // Compares every resolved control with what the model expects.
  task automatic chkout();
    logic [15:0] tr, ta, tb;
    int m;
    tr = mdl[3];
    ta = mdl[4];
    tb = mdl[5];
    repeat (2) @(posedge mclk);
    m = int'(ta[13:11]);
    chk(32'(monitorConnect), (m >= 1 && m <= 4) ? 32'(1 << (m - 1)) : 32'h0);
    m = int'(ta[10:8]);
    chk(32'(testbusConnect), (m >= 1 && m <= 3) ? 32'(1 << (m - 1)) : 32'h0);
    m = int'(tb[3:0]);
    chk(32'(testbusWord), (m >= 1 && m <= 9) ? 32'(readbackWords[(m - 1) * 16 +: 16]) : 32'h0);
    chk(32'(cmpClk), 32'(ta[15] ? tb[12:9] : autoCmpClk));
    chk(32'(ilimitSetting), 32'(ta[14] ? tb[8:4] : 5'(adapt)));
    chk(32'(adaptiveIlimit), 32'(adapt));
    chk(32'(highCmpTrim), 32'(tr[13] ? tr[12:7] : autoHighTrim));
    chk(32'(lowCmpTrim), 32'(tr[6] ? tr[5:0] : autoLowTrim));
    chk({aux18Ctrl, sleepCtrlA}, {mdl[0], mdl[1]});
    chk({sleepCtrlB, testForceA}, {mdl[2], mdl[4]});
  endtask

  // An idle spell of n cycles, then the expected step of the limit.
  task automatic idle(input int n, input int delta);
    converterIdle <= 1'b1;
    repeat (n) @(posedge mclk);
    converterIdle <= 1'b0;
    repeat (10) @(posedge mclk);
    adapt += delta;
    chkout();
  endtask

  // Main sequence: reset values, idle adaptation, then randomised register traffic.
  initial begin
    logic [31:0] q;
    logic [159:0] w;
    mask = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h3FFF, 16'hFFFF, 16'h1FFF};
    offs = '{bcc_pkg::OFF_AUX18_RAIL, bcc_pkg::OFF_RET_A, bcc_pkg::OFF_RET_B, bcc_pkg::OFF_TRIM,
      bcc_pkg::OFF_TEST_A, bcc_pkg::OFF_TEST_B};
    mdl[0] = {1'b1, 1'b0, 4'hF, 5'h04, 5'h10};
    mdl[1] = {3'h5, 5'h0A, 3'h5, 5'h06};
    mdl[2] = {3'h5, 5'h0A, 3'h2, 5'h06};
    mdl[3] = 16'h0000;
    mdl[4] = 16'h0000;
    mdl[5] = 16'h0000;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rchk(k);
    end
    bus(1'b0, 32'h500000A2, 16'h0000, q);
    chk(q, 32'h0);
    chkout();
    // A write on the low byte lane alone must leave the high byte as it was.
    avs_byteenable <= 4'h1;
    bus(1'b1, offs[1], 16'h1234, q);
    mdl[1][7:0] = 8'h34;
    avs_byteenable <= 4'hF;
    rchk(1);
    // Short spells are below the minimum, 22 cycles lies inside the band, 40 is beyond it.
    idle(5, 1);
    idle(22, 0);
    idle(40, -1);
    idle(5, 1);
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      wreg(i % 4, rnd[15:0]);
      rnd = lfsr(rnd);
      wreg(4, {rnd[15:14], i[2:0], i[2:0], rnd[7:0]});
      rnd = lfsr(rnd);
      wreg(5, {rnd[15:4], i[3:0]});
      bus(1'b1, 32'h500000A2, rnd[31:16], q);
      for (int j = 0; j < 5; j++) begin
        rnd = lfsr(rnd);
        w = {w[127:0], rnd};
      end
      readbackWords <= w[143:0];
      {autoCmpClk, autoHighTrim, autoLowTrim} <= rnd[15:0];
      for (int k = 0; k < 6; k++) begin
        rchk(k);
      end
      chkout();
    end
    conclude();
  end

  // Overall limit on the run length.
  initial begin
    repeat (100000) @(posedge mclk);
    errTotal++;
    conclude();
  end
endmodule
`default_nettype wire
